// ---- hw/dua_pkg.sv ----
// Operation
// - reset or clock mode not 3 holds suspended
// - receiver reset in mode 3 enters full
// - first zero selects expect, lowest channel wins
// - grant latches address, strobe; a grant from full also copies enables
// - load suspend count, decrement every byte in expect
// - underflow: interrupt, strobe off, suspended
// - seven ones: limited, strobe off, clear served bit of copy
// - frame recognised: expect moves to receive
// - end of frame: limited, strobe off, clear
// - limited monitors round copy and enable mask
// - zero in limited grants like full selection
// - n idle frames return to full selection
// - n zero skips limited selection
// - state readable in state register bits 7:5
// - carrier select picks monitor bit or command
// - available drives one or x0xx, blocked otherwise
// - busy states block all enabled channels but served channel
package dua_pkg;
  localparam int NCHAN = 32;
  localparam int AW = 4;
  localparam int DW = 8;
  localparam logic [3:0] OFS_ENABLE0 = 4'h0;
  localparam logic [3:0] OFS_ENABLE3 = 4'h3;
  localparam logic [3:0] OFS_SUSPEND = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h5;
  localparam logic [3:0] OFS_IDLE_N = 4'h6;
  localparam logic [3:0] OFS_STATE = 4'h7;
  localparam int MODE_CARRIER_BIT = 7;
  localparam int MODE_SIGNAL_EN_BIT = 6;
  localparam logic [1:0] ARB_CLOCK_MODE = 2'h3;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SUSPEND = 8'hff;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_IDLE_N = 8'h00;
  localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;
  localparam logic [2:0] ONES_ABORT_M1 = 3'h6;
  // state codes
  typedef enum logic [2:0] {
    ST_SUSPENDED = 3'b000,
    ST_FULL_SEL = 3'b001,
    ST_EXPECT = 3'b010,
    ST_RECEIVE = 3'b011,
    ST_LIMITED = 3'b100
  } dua_state_t;
  typedef struct packed {
    logic frame_tick;
    logic bit_valid;
    logic [31:0] bits;
  } dua_hwy_t;
  typedef struct packed {
    logic [1:0] clock_mode;
    logic rx_reset;
    logic frame_found;
    logic frame_end;
  } dua_rxev_t;
endpackage : dua_pkg

// ---- hw/dua_suspend_counter.sv ----
`timescale 1ns/1ps
module dua_suspend_counter #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic dec,
  output logic [WIDTH-1:0] count,
  output logic underflow
);
  if (WIDTH < 1 || WIDTH > 16)
  begin : g_chk
    $error("suspend counter width out of range");
  end
  logic [WIDTH-1:0] count_r;
  assign count = count_r;
  // a decrement at zero is the underflow; counter stays at zero
  assign underflow = dec && !load && (count_r == '0);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      count_r <= '0;
    else if (load)
      count_r <= load_value;
    else if (dec && count_r != '0)
      count_r <= count_r - WIDTH'(1);
  end
endmodule : dua_suspend_counter

// ---- hw/dua_availability_signaller.sv ----
`timescale 1ns/1ps
module dua_availability_signaller (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mode3,
  input wire dua_pkg::dua_state_t state,
  input wire logic [4:0] served,
  input wire logic [31:0] enable_mask,
  input wire logic [31:0] round_copy,
  input wire logic signal_en,
  input wire logic carrier_sel,
  input wire logic [31:0] cm_mr,
  input wire logic [31:0] cm_ci,
  output logic [31:0] mr_out,
  output logic [31:0] ci_out
);
  logic [31:0] avail;
  logic [31:0] managed;
  always_comb
  begin
    avail = '0;
    managed = '0;
    if (!signal_en)
    begin
      avail = enable_mask;
      managed = enable_mask;
    end
    else if (mode3)
    begin
      managed = enable_mask;
      case (state)
        dua_pkg::ST_FULL_SEL: avail = enable_mask;
        dua_pkg::ST_LIMITED: avail = enable_mask & round_copy;
        dua_pkg::ST_EXPECT, dua_pkg::ST_RECEIVE:
          avail = enable_mask & (32'h1 << served);
        default: managed = '0;
      endcase
    end
  end
  // monitor bit 1 or command bit 2 low means available
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mr_out <= '0;
      ci_out <= '0;
    end
    else
    begin
      mr_out <= carrier_sel ? ((managed & avail) | (~managed & cm_mr))
        : cm_mr;
      ci_out <= carrier_sel ? cm_ci
        : ((managed & ~avail) | (~managed & cm_ci));
    end
  end
endmodule : dua_availability_signaller

// ---- hw/dua_grant_state_machine.sv ----
`timescale 1ns/1ps
module dua_grant_state_machine #(
  parameter int SCV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire dua_pkg::dua_hwy_t hwy,
  input wire dua_pkg::dua_rxev_t rx_ev,
  input wire logic [31:0] cm_mr,
  input wire logic [31:0] cm_ci,
  output logic [31:0] mr_out,
  output logic [31:0] ci_out,
  output logic rx_strobe,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic suspend_irq
);
  if (SCV_W != 8)
  begin : g_chk
    $error("suspend count width must match register width");
  end

  function automatic logic [4:0] lowest_set(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
        idx = 5'(i);
    end
    return idx;
  endfunction : lowest_set

  dua_pkg::dua_state_t state_r;
  dua_pkg::dua_state_t state_nxt;
  logic [31:0] dce_r;
  logic [31:0] round_enable_copy_r;
  logic [7:0] scv_r;
  logic [7:0] amo_r;
  logic [7:0] idle_n_r;
  logic [7:0] idle_cnt_r;
  logic [4:0] chan_r;
  logic [2:0] ones_cnt_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rdata_r;
  logic strobe_r;
  logic rx_bit_r;
  logic rx_bit_valid_r;
  logic irq_r;
  logic mode3;
  logic active;
  logic [31:0] mon_mask;
  logic [31:0] req;
  logic [4:0] win;
  logic grant;
  logic served_bit;
  logic seventh_one;
  logic byte_done;
  logic underflow;
  logic [7:0] susp_count;
  logic [7:0] idle_cnt_nxt;
  dua_pkg::dua_state_t after_frame;

  assign mode3 = (rx_ev.clock_mode == dua_pkg::ARB_CLOCK_MODE);
  assign active = mode3 && !rx_ev.rx_reset;
  // full selection watches the whole mask, limited the mask anded with the round copy
  assign mon_mask = (state_r == dua_pkg::ST_LIMITED) ? (dce_r & round_enable_copy_r) : dce_r;
  assign req = ~hwy.bits & mon_mask;
  assign win = lowest_set(req);
  assign grant = hwy.bit_valid && (req != '0)
    && (state_r == dua_pkg::ST_FULL_SEL || state_r == dua_pkg::ST_LIMITED);
  assign served_bit = hwy.bits[chan_r];
  assign seventh_one = hwy.bit_valid && served_bit && (ones_cnt_r == dua_pkg::ONES_ABORT_M1);
  // one byte is four highway frames of two bits each
  assign byte_done = hwy.bit_valid && (state_r == dua_pkg::ST_EXPECT)
    && (bit_cnt_r == dua_pkg::BITS_PER_BYTE_M1);
  assign after_frame = (idle_n_r == 8'h00)
    ? dua_pkg::ST_FULL_SEL : dua_pkg::ST_LIMITED;
  assign idle_cnt_nxt = idle_cnt_r + 8'h01;

  always_comb
  begin
    state_nxt = state_r;
    if (!mode3)
      state_nxt = dua_pkg::ST_SUSPENDED;
    else if (rx_ev.rx_reset)
      state_nxt = dua_pkg::ST_FULL_SEL;
    else
    begin
      case (state_r)
        dua_pkg::ST_SUSPENDED: state_nxt = dua_pkg::ST_SUSPENDED;
        dua_pkg::ST_FULL_SEL:
          if (grant)
            state_nxt = dua_pkg::ST_EXPECT;
        dua_pkg::ST_LIMITED:
          if (grant)
            state_nxt = dua_pkg::ST_EXPECT;
          else if (hwy.frame_tick && idle_cnt_nxt >= idle_n_r)
            state_nxt = dua_pkg::ST_FULL_SEL;
        dua_pkg::ST_EXPECT:
          if (underflow)
            state_nxt = dua_pkg::ST_SUSPENDED;
          else if (seventh_one)
            state_nxt = after_frame;
          else if (rx_ev.frame_found)
            state_nxt = dua_pkg::ST_RECEIVE;
        dua_pkg::ST_RECEIVE:
          if (rx_ev.frame_end)
            state_nxt = after_frame;
        default: state_nxt = dua_pkg::ST_SUSPENDED;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_r <= dua_pkg::ST_SUSPENDED;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      chan_r <= 5'h00;
    else if (active && grant)
      chan_r <= win;
  end

  // round copy loaded on a grant from full, served bit dropped after a frame
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      round_enable_copy_r <= '0;
    else if (active && grant && state_r == dua_pkg::ST_FULL_SEL)
      round_enable_copy_r <= dce_r;
    else if (active && (state_r == dua_pkg::ST_EXPECT || state_r == dua_pkg::ST_RECEIVE)
             && (state_nxt == dua_pkg::ST_LIMITED || state_nxt == dua_pkg::ST_FULL_SEL))
      round_enable_copy_r[chan_r] <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || state_r != dua_pkg::ST_EXPECT)
    begin
      ones_cnt_r <= 3'h0;
      bit_cnt_r <= 3'h0;
    end
    else if (hwy.bit_valid)
    begin
      ones_cnt_r <= served_bit ? ones_cnt_r + 3'h1 : 3'h0;
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || state_r != dua_pkg::ST_LIMITED)
      idle_cnt_r <= 8'h00;
    else if (hwy.frame_tick)
      idle_cnt_r <= idle_cnt_nxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strobe_r <= 1'b0;
      irq_r <= 1'b0;
      rx_bit_r <= 1'b0;
      rx_bit_valid_r <= 1'b0;
    end
    else
    begin
      strobe_r <= (state_nxt == dua_pkg::ST_EXPECT)
        || (state_nxt == dua_pkg::ST_RECEIVE);
      irq_r <= active && state_r == dua_pkg::ST_EXPECT && underflow;
      rx_bit_r <= served_bit;
      rx_bit_valid_r <= hwy.bit_valid && strobe_r;
    end
  end

  dua_suspend_counter #(
    .WIDTH(SCV_W)
  ) u_suspend (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(active && grant),
    .load_value(scv_r),
    .dec(byte_done),
    .count(susp_count),
    .underflow(underflow)
  );

  dua_availability_signaller u_signal (
    .ref_clk(ref_clk),
    .rst(rst),
    .mode3(mode3),
    .state(state_r),
    .served(chan_r),
    .enable_mask(dce_r),
    .round_copy(round_enable_copy_r),
    .signal_en(amo_r[dua_pkg::MODE_SIGNAL_EN_BIT]),
    .carrier_sel(amo_r[dua_pkg::MODE_CARRIER_BIT]),
    .cm_mr(cm_mr),
    .cm_ci(cm_ci),
    .mr_out(mr_out),
    .ci_out(ci_out)
  );

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dce_r <= {4{dua_pkg::RST_ENABLE}};
      scv_r <= dua_pkg::RST_SUSPEND;
      amo_r <= dua_pkg::RST_MODE;
      idle_n_r <= dua_pkg::RST_IDLE_N;
    end
    else if (reg_wr)
    begin
      if (reg_addr <= dua_pkg::OFS_ENABLE3)
        dce_r[reg_addr[1:0]*8 +: 8] <= reg_wdata;
      if (reg_addr == dua_pkg::OFS_SUSPEND)
        scv_r <= reg_wdata;
      if (reg_addr == dua_pkg::OFS_MODE)
        amo_r <= reg_wdata;
      if (reg_addr == dua_pkg::OFS_IDLE_N)
        idle_n_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !reg_rd)
      rdata_r <= 8'h00;
    else if (reg_addr <= dua_pkg::OFS_ENABLE3)
      rdata_r <= dce_r[reg_addr[1:0]*8 +: 8];
    else
    begin
      case (reg_addr)
        dua_pkg::OFS_SUSPEND: rdata_r <= scv_r;
        dua_pkg::OFS_MODE: rdata_r <= amo_r;
        dua_pkg::OFS_IDLE_N: rdata_r <= idle_n_r;
        dua_pkg::OFS_STATE: rdata_r <= {state_r, chan_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign rx_strobe = strobe_r;
  assign rx_bit = rx_bit_r;
  assign rx_bit_valid = rx_bit_valid_r;
  assign suspend_irq = irq_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_mode_suspend: assert property (!mode3 |=> state_r == dua_pkg::ST_SUSPENDED)
    else $error("not suspended outside clock mode 3");
  a_reset_full: assert property (mode3 && rx_ev.rx_reset
    |=> state_r == dua_pkg::ST_FULL_SEL)
    else $error("receiver reset did not enter full selection");
  a_zero_grant: assert property (active && grant
    |=> state_r == dua_pkg::ST_EXPECT && chan_r == $past(win) && rx_strobe)
    else $error("zero did not grant lowest channel");
  a_round_copy: assert property (active && grant
    && state_r == dua_pkg::ST_FULL_SEL |=> round_enable_copy_r == $past(dce_r))
    else $error("round copy not loaded");
  a_count_reload: assert property (active && grant
    |=> susp_count == $past(scv_r))
    else $error("suspend counter not reloaded");
  a_underflow_stop: assert property (active && state_r == dua_pkg::ST_EXPECT
    && underflow |=> state_r == dua_pkg::ST_SUSPENDED && suspend_irq && !rx_strobe)
    else $error("underflow did not suspend");
  a_ones_limit: assert property (active && state_r == dua_pkg::ST_EXPECT
    && !underflow && seventh_one |=> !rx_strobe && !round_enable_copy_r[$past(chan_r)])
    else $error("seven ones did not release channel");
  a_found_recv: assert property (active && state_r == dua_pkg::ST_EXPECT
    && !underflow && !seventh_one && rx_ev.frame_found |=> state_r == dua_pkg::ST_RECEIVE)
    else $error("frame found not honoured");
  a_end_release: assert property (active
    && state_r == dua_pkg::ST_RECEIVE && rx_ev.frame_end
    |=> state_r == $past(after_frame) && !rx_strobe)
    else $error("end of frame did not release");
  a_state_read: assert property (reg_rd && reg_addr == dua_pkg::OFS_STATE
    |=> reg_rdata[7:5] == $past(state_r))
    else $error("state read back wrong");
  a_limited_mask: assert property (active && grant
    && state_r == dua_pkg::ST_LIMITED |-> dce_r[win] && round_enable_copy_r[win])
    else $error("limited selection granted an excluded channel");
  a_idle_return: assert property (active && state_r == dua_pkg::ST_LIMITED
    && hwy.frame_tick && !grant && idle_cnt_r == idle_n_r - 8'h01
    |=> state_r == dua_pkg::ST_FULL_SEL)
    else $error("idle frames did not return to full selection");
  a_skip_limited: assert property (idle_n_r == 8'h00
    && state_r != dua_pkg::ST_LIMITED |=> state_r != dua_pkg::ST_LIMITED)
    else $error("limited selection entered with zero idle count");
  a_bit_forward: assert property (hwy.bit_valid && rx_strobe
    |=> rx_bit_valid && rx_bit == $past(served_bit))
    else $error("served bit not forwarded");
  c_grant: cover property (state_r == dua_pkg::ST_FULL_SEL ##1 state_r == dua_pkg::ST_EXPECT);
  c_frame: cover property (state_r == dua_pkg::ST_RECEIVE ##1 state_r == dua_pkg::ST_LIMITED);
  c_idle_back: cover property (state_r == dua_pkg::ST_LIMITED ##1 state_r == dua_pkg::ST_FULL_SEL);
  c_limited_grant: cover property (state_r == dua_pkg::ST_LIMITED
    ##1 state_r == dua_pkg::ST_EXPECT);
  c_suspend: cover property (suspend_irq);
endmodule : dua_grant_state_machine

// ---- tb/dua_subscriber_model.sv ----
`timescale 1ns/1ps
module dua_subscriber_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] zero_mask,
  output dua_pkg::dua_hwy_t hwy
);
  logic [4:0] pos_r;
  logic tick_r;
  logic slot_r;
  always_ff @(posedge ref_clk)
  begin
    pos_r <= rst ? 5'h00 : pos_r + 5'h01;
  end
  // two d bit slots per 32-cycle frame
  always_ff @(posedge ref_clk)
  begin
    tick_r <= !rst && pos_r == 5'h00;
    slot_r <= !rst && (pos_r == 5'h03 || pos_r == 5'h13);
  end
  // idle lines read as ones; outside the slots a changing pattern
  assign hwy = {tick_r, slot_r, slot_r ? ~zero_mask : {32{pos_r[0]}}};
endmodule : dua_subscriber_model

// ---- tb/test_dchannel_upstream_arbiter.sv ----
`timescale 1ns/1ps
module test_dchannel_upstream_arbiter;
  localparam logic [31:0] CH5 = 32'h0000_0020;
  localparam logic [31:0] CH9 = 32'h0000_0200;
  localparam logic [31:0] MASK = 32'h0000_0223;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  dua_pkg::dua_hwy_t hwy;
  dua_pkg::dua_rxev_t rx_ev = '0;
  logic [31:0] cm_mr = 32'h0000_0001;
  logic [31:0] cm_ci = 32'hffff_fffe;
  logic [31:0] zero_mask = 32'h0;
  logic [31:0] mr_out;
  logic [31:0] ci_out;
  logic rx_strobe;
  logic rx_bit;
  logic rx_bit_valid;
  logic suspend_irq;
  logic [31:0] v;
  int bad_count = 0;
  int total_checks = 0;
  int irq_seen = 0;
  int served_ones = 0;
  int served_zeros = 0;

  always #5 ref_clk = ~ref_clk;

  dua_grant_state_machine dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hwy(hwy), .rx_ev(rx_ev), .cm_mr(cm_mr), .cm_ci(cm_ci), .mr_out(mr_out),
    .ci_out(ci_out), .rx_strobe(rx_strobe), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .suspend_irq(suspend_irq));
  dua_subscriber_model far_u (.ref_clk(ref_clk), .rst(rst), .zero_mask(zero_mask),
    .hwy(hwy));

  always @(posedge ref_clk)
  begin
    if (suspend_irq === 1'b1)
    begin
      irq_seen <= irq_seen + 1;
    end
    // forwarded served bits, counted by value
    if (rx_bit_valid === 1'b1 && rx_bit === 1'b1)
    begin
      served_ones <= served_ones + 1;
    end
    if (rx_bit_valid === 1'b1 && rx_bit === 1'b0)
    begin
      served_zeros <= served_zeros + 1;
    end
  end

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = {24'h000000, reg_rdata};
  endtask : rd

  task automatic chk_state(input logic [2:0] s);
    rd(dua_pkg::OFS_STATE);
    check({29'h0, v[7:5]}, {29'h0, s});
  endtask : chk_state

  // 0 receiver reset, 1 frame found, 2 frame end
  task automatic pulse(input int which);
    @(posedge ref_clk);
    case (which)
      0: rx_ev.rx_reset <= 1'b1;
      1: rx_ev.frame_found <= 1'b1;
      default: rx_ev.frame_end <= 1'b1;
    endcase
    @(posedge ref_clk);
    rx_ev.rx_reset <= 1'b0;
    rx_ev.frame_found <= 1'b0;
    rx_ev.frame_end <= 1'b0;
  endtask : pulse

  // hold the zero pattern for n d bit slots, then idle ones
  task automatic slots(input logic [31:0] mask, input int n);
    @(posedge ref_clk);
    zero_mask <= mask;
    repeat (n)
    begin
      @(posedge ref_clk);
      while (hwy.bit_valid !== 1'b1)
      begin
        @(posedge ref_clk);
      end
    end
    @(posedge ref_clk);
    zero_mask <= 32'h0;
  endtask : slots

  task automatic scn_enter_full;
    chk_state(dua_pkg::ST_SUSPENDED);
    rd(dua_pkg::OFS_SUSPEND);
    check(v, 32'h0000_00ff);
    wr(4'h9, 8'h5a);
    rd(4'h9);
    check(v, 32'h0);
    pulse(0);
    chk_state(dua_pkg::ST_SUSPENDED);
    wr(dua_pkg::OFS_ENABLE0, 8'h20);
    wr(4'h1, 8'h02);
    wr(dua_pkg::OFS_SUSPEND, 8'h03);
    check(ci_out & MASK, 32'h0000_0002);
    check(mr_out & MASK, 32'h0000_0001);
    wr(dua_pkg::OFS_MODE, 8'hc0);
    rx_ev.clock_mode <= dua_pkg::ARB_CLOCK_MODE;
    pulse(0);
    chk_state(dua_pkg::ST_FULL_SEL);
    check(mr_out & MASK, 32'h0000_0221);
  endtask : scn_enter_full

  task automatic scn_grant_receive;
    slots(CH5 | CH9, 1);
    chk_state(dua_pkg::ST_EXPECT);
    check(v & 32'h1f, 32'h05);
    check(32'(rx_strobe), 32'h1);
    check(mr_out & MASK, 32'h0000_0021);
    pulse(1);
    chk_state(dua_pkg::ST_RECEIVE);
    pulse(2);
    chk_state(dua_pkg::ST_FULL_SEL);
    check(32'(rx_strobe), 32'h0);
  endtask : scn_grant_receive

  task automatic scn_limited;
    int o0;
    wr(dua_pkg::OFS_IDLE_N, 8'h04);
    slots(CH5 | CH9, 1);
    o0 = served_ones;
    slots(32'h0, 7);
    chk_state(dua_pkg::ST_LIMITED);
    check(served_ones - o0, 32'h0000_0007);
    check(32'(rx_strobe), 32'h0);
    check(mr_out & MASK, 32'h0000_0201);
    slots(CH5 | CH9, 1);
    chk_state(dua_pkg::ST_EXPECT);
    check(v & 32'h1f, 32'h09);
    pulse(1);
    pulse(2);
    chk_state(dua_pkg::ST_LIMITED);
    slots(CH5 | CH9, 1);
    chk_state(dua_pkg::ST_LIMITED);
    slots(32'h0, 10);
    chk_state(dua_pkg::ST_FULL_SEL);
  endtask : scn_limited

  task automatic scn_underflow;
    int z0;
    wr(dua_pkg::OFS_SUSPEND, 8'h01);
    slots(CH5, 1);
    z0 = served_zeros;
    slots(CH5, 12);
    chk_state(dua_pkg::ST_EXPECT);
    check(served_zeros - z0, 32'h0000_000c);
    slots(CH5, 6);
    chk_state(dua_pkg::ST_SUSPENDED);
    check(irq_seen, 32'h1);
    check(32'(rx_strobe), 32'h0);
    slots(CH5, 1);
    chk_state(dua_pkg::ST_SUSPENDED);
    pulse(0);
    chk_state(dua_pkg::ST_FULL_SEL);
  endtask : scn_underflow

  task automatic scn_carrier;
    wr(dua_pkg::OFS_MODE, 8'h40);
    rd(dua_pkg::OFS_MODE);
    check(ci_out & MASK, 32'h0000_0002);
    check(mr_out & MASK, 32'h0000_0001);
    rx_ev.clock_mode <= 2'h1;
    chk_state(dua_pkg::ST_SUSPENDED);
  endtask : scn_carrier

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    scn_enter_full();
    scn_grant_receive();
    scn_limited();
    scn_underflow();
    scn_carrier();
    complete_run();
  end

  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule : test_dchannel_upstream_arbiter
